// ### shared/sdw_regs.svh
// Constants for the serial converter write link and its host controller
`ifndef SDW_REGS_SVH
`define SDW_REGS_SVH

`define SDW_WORD_BITS      24
`define SDW_CODE_BITS      16
`define SDW_CODE_LSB       0
`define SDW_CODE_MSB       15
`define SDW_MODE_LSB       16
`define SDW_MODE_MSB       17
`define SDW_CODE_RESET     16'h0000
`define SDW_MODE_RESET     2'h0
`define SDW_WORD_RESET     24'h000000
`define SDW_COUNT_RESET    5'h00
`define SDW_COUNT_LAST     5'h17
`define SDW_CODE_SCALE     65536
`define SDW_CLOCK_MHZ      25
`define SDW_WAKE_NS        2500
`define SDW_SYNC_HIGH_NS   33
`define SDW_LINK_MAX_MHZ   30
// APB register offsets of the host controller
`define SDW_REG_DATA       12'h000
`define SDW_REG_CTRL       12'h004
`define SDW_REG_STATUS     12'h008
`define SDW_REG_DIV        12'h00C
`define SDW_CTRL_GO_BIT    0
`define SDW_CTRL_ABORT_BIT 1
`define SDW_DIV_RESET      8'h02

`endif

// ### shared/sdw_pkg.sv
// Types shared by both ends of the serial converter write link
package sdw_pkg;
  typedef enum logic [1:0] {
    SDW_MODE_NORMAL,
    SDW_MODE_PD_1K,
    SDW_MODE_PD_100K,
    SDW_MODE_PD_HIZ
  } sdw_mode_type;
endpackage

// ### shared/sdw_link_if.sv
// Three-wire write link between the host controller and the converter end
`timescale 1ns/1ps
interface sdw_link_if;
  logic sync_n;
  logic sclk;
  logic sdata;
  modport host (output sync_n, output sclk, output sdata);
  modport device (input sync_n, input sclk, input sdata);
endinterface

// ### rtl/sdw_device.sv
// Converter end: receives 24-bit frames and holds code and power mode
`timescale 1ns/1ps
`include "sdw_regs.svh"

module sdw_device #(
  parameter int WAKE_NS   = `SDW_WAKE_NS,
  parameter int CLOCK_MHZ = `SDW_CLOCK_MHZ
) (
  input  wire logic                    clock,
  input  wire logic                    nrst,
  sdw_link_if.device                   link,
  output logic [`SDW_CODE_BITS-1:0]    code,
  output sdw_pkg::sdw_mode_type        mode,
  output logic                         amp_connected,
  output logic                         term_1k,
  output logic                         term_100k,
  output logic                         output_valid,
  output logic                         frame_applied,
  output logic                         frame_aborted
);
  import sdw_pkg::*;

  // Wake delay in clock cycles, rounded down, at least one
  localparam int WAKE_RAW    = (WAKE_NS * CLOCK_MHZ) / 1000;
  localparam int WAKE_CYCLES = (WAKE_RAW < 1) ? 1 : WAKE_RAW;
  localparam int WAKE_W      = $clog2(WAKE_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts when stages 2 and 3 agree

  logic [2:0] sync_pipe;
  logic [2:0] sclk_pipe;
  logic [2:0] data_pipe;
  logic       sync_level;
  logic       sclk_level;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync_pipe <= 3'h7;
      sclk_pipe <= 3'h0;
      data_pipe <= 3'h0;
    end else begin
      sync_pipe <= {sync_pipe[1:0], link.sync_n};
      sclk_pipe <= {sclk_pipe[1:0], link.sclk};
      data_pipe <= {data_pipe[1:0], link.sdata};
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync_level <= 1'b1;
      sclk_level <= 1'b0;
    end else begin
      if (sync_pipe[1] == sync_pipe[2]) begin
        sync_level <= sync_pipe[2];
      end
      if (sclk_pipe[1] == sclk_pipe[2]) begin
        sclk_level <= sclk_pipe[2];
      end
    end
  end

  // Data is stable around the clock edge, so stage 3 is the sampled bit
  logic sync_fall;
  logic sync_rise;
  logic sclk_fall;
  assign sync_fall = sync_level && (sync_pipe[1] == sync_pipe[2]) && !sync_pipe[2];
  assign sync_rise = !sync_level && (sync_pipe[1] == sync_pipe[2]) && sync_pipe[2];
  assign sclk_fall = sclk_level && (sclk_pipe[1] == sclk_pipe[2]) && !sclk_pipe[2];

  ////////////////////////////////////////////////////////////////////////////
  // Frame reception

  typedef enum logic [1:0] {
    SDW_RX_IDLE,
    SDW_RX_SHIFT,
    SDW_RX_DONE
  } sdw_rx_type;

  sdw_rx_type                 rx_state;
  logic [`SDW_WORD_BITS-1:0]  shift_word;
  logic [4:0]                 bit_count;
  logic [`SDW_WORD_BITS-1:0]  next_word;
  logic                       last_edge;

  assign next_word = {shift_word[`SDW_WORD_BITS-2:0], data_pipe[2]};
  assign last_edge = (rx_state == SDW_RX_SHIFT) && sclk_fall && !sync_rise
                     && (bit_count == `SDW_COUNT_LAST);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rx_state   <= SDW_RX_IDLE;
      shift_word <= `SDW_WORD_RESET;
      bit_count  <= `SDW_COUNT_RESET;
    end else begin
      case (rx_state)
        SDW_RX_IDLE: begin
          if (sync_fall) begin
            rx_state   <= SDW_RX_SHIFT;
            bit_count  <= `SDW_COUNT_RESET;
            shift_word <= `SDW_WORD_RESET;
          end
        end
        SDW_RX_SHIFT: begin
          if (sync_rise) begin
            rx_state   <= SDW_RX_IDLE;
            shift_word <= `SDW_WORD_RESET;
            bit_count  <= `SDW_COUNT_RESET;
          end else if (sclk_fall) begin
            shift_word <= next_word;
            bit_count  <= bit_count + 5'h01;
            if (bit_count == `SDW_COUNT_LAST) begin
              rx_state <= SDW_RX_DONE;
            end
          end
        end
        SDW_RX_DONE: begin
          // Further clock edges do nothing until a fresh select fall
          if (sync_rise) begin
            rx_state  <= SDW_RX_IDLE;
            bit_count <= `SDW_COUNT_RESET;
          end
        end
        default: begin
          rx_state <= SDW_RX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Held code and mode: only a complete frame updates them

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      code <= `SDW_CODE_RESET;
      mode <= SDW_MODE_NORMAL;
    end else if (last_edge) begin
      // Code stored unsigned; analog side scales by SDW_CODE_SCALE
      code <= next_word[`SDW_CODE_MSB:`SDW_CODE_LSB];
      mode <= sdw_mode_type'(next_word[`SDW_MODE_MSB:`SDW_MODE_LSB]);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      frame_applied <= 1'b0;
      frame_aborted <= 1'b0;
    end else begin
      frame_applied <= last_edge;
      frame_aborted <= (rx_state == SDW_RX_SHIFT) && sync_rise;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage control and wake delay

  always_comb begin
    amp_connected = 1'b0;
    term_1k       = 1'b0;
    term_100k     = 1'b0;
    case (mode)
      SDW_MODE_NORMAL:  amp_connected = 1'b1;
      SDW_MODE_PD_1K:   term_1k = 1'b1;
      SDW_MODE_PD_100K: term_100k = 1'b1;
      SDW_MODE_PD_HIZ:  amp_connected = 1'b0;
      default:          amp_connected = 1'b0;
    endcase
  end

  logic [WAKE_W-1:0] wake_count;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wake_count   <= '0;
      output_valid <= 1'b1;
    end else if (mode != SDW_MODE_NORMAL) begin
      wake_count   <= WAKE_W'(WAKE_CYCLES);
      output_valid <= 1'b0;
    end else if (wake_count != '0) begin
      wake_count   <= wake_count - 1'b1;
      output_valid <= (wake_count == WAKE_W'(1));
    end else begin
      output_valid <= 1'b1;
    end
  end
  // three-stage sampling at 25 MHz resolves host link below 6.25 MHz
  // faster links need the device clock scaled up accordingly.
endmodule

// ### rtl/sdw_host.sv
// Host end: APB-programmed controller that sends 24-bit frames
`timescale 1ns/1ps
`include "sdw_regs.svh"

module sdw_host (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  sdw_link_if.host          link
);
  import sdw_pkg::*;

  localparam int SYNC_HIGH_CYC = (`SDW_SYNC_HIGH_NS * `SDW_CLOCK_MHZ + 999) / 1000;
  localparam int GAP_CYC       = (SYNC_HIGH_CYC < 1) ? 1 : SYNC_HIGH_CYC;

  typedef enum logic [1:0] {
    SDW_TX_IDLE,
    SDW_TX_SEND,
    SDW_TX_GAP
  } sdw_tx_type;

  sdw_tx_type                 tx_state;
  logic [`SDW_WORD_BITS-1:0]  tx_word;
  logic [`SDW_WORD_BITS-1:0]  data_reg;
  logic [7:0]                 div_reg;
  logic [7:0]                 div_count;
  logic [4:0]                 bits_left;
  logic [3:0]                 gap_count;
  logic                       half_tick;
  logic                       aborted;
  logic                       done_count_en;
  logic [15:0]                frames_sent;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, error on unmapped address

  logic access;
  logic mapped;
  logic wr;
  assign access  = psel && penable;
  assign mapped  = (paddr == `SDW_REG_DATA) || (paddr == `SDW_REG_CTRL)
                   || (paddr == `SDW_REG_STATUS) || (paddr == `SDW_REG_DIV);
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign wr      = access && pwrite && mapped;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      data_reg <= `SDW_WORD_RESET;
      div_reg  <= `SDW_DIV_RESET;
    end else if (wr) begin
      if (paddr == `SDW_REG_DATA) begin
        data_reg <= pwdata[`SDW_WORD_BITS-1:0];
      end
      if (paddr == `SDW_REG_DIV && pwdata[7:0] != 8'h00) begin
        div_reg <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `SDW_REG_DATA:   prdata <= {8'h00, data_reg};
        `SDW_REG_STATUS: prdata <= {frames_sent, 13'h0000, aborted,
                                    tx_state == SDW_TX_IDLE, tx_state != SDW_TX_IDLE};
        `SDW_REG_DIV:    prdata <= {24'h000000, div_reg};
        default:         prdata <= 32'h00000000;
      endcase
    end
  end

  logic go;
  logic abort_req;
  assign go        = wr && (paddr == `SDW_REG_CTRL) && pwdata[`SDW_CTRL_GO_BIT];
  assign abort_req = wr && (paddr == `SDW_REG_CTRL) && pwdata[`SDW_CTRL_ABORT_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Link clock divider: one enable pulse per half link period

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div_count <= 8'h00;
    end else if (tx_state != SDW_TX_SEND || half_tick) begin
      div_count <= 8'h00;
    end else begin
      div_count <= div_count + 8'h01;
    end
  end
  assign half_tick = (tx_state == SDW_TX_SEND) && (div_count == div_reg - 8'h01);

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer: data changes on rising link edge, device samples on falling

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_state   <= SDW_TX_IDLE;
      tx_word    <= `SDW_WORD_RESET;
      bits_left  <= `SDW_COUNT_RESET;
      gap_count  <= 4'h0;
      link.sync_n <= 1'b1;
      link.sclk   <= 1'b0;
      link.sdata  <= 1'b0;
      aborted    <= 1'b0;
    end else begin
      case (tx_state)
        SDW_TX_IDLE: begin
          if (go) begin
            tx_state    <= SDW_TX_SEND;
            link.sync_n <= 1'b0;
            link.sclk   <= 1'b1;
            link.sdata  <= data_reg[`SDW_WORD_BITS-1];
            tx_word     <= {data_reg[`SDW_WORD_BITS-2:0], 1'b0};
            bits_left   <= `SDW_COUNT_LAST;
            aborted     <= 1'b0;
          end
        end
        SDW_TX_SEND: begin
          if (abort_req) begin
            tx_state    <= SDW_TX_GAP;
            link.sync_n <= 1'b1;
            link.sclk   <= 1'b0;
            gap_count   <= 4'(GAP_CYC);
            aborted     <= 1'b1;
          end else if (half_tick) begin
            link.sclk <= !link.sclk;
            if (!link.sclk) begin
              link.sdata <= tx_word[`SDW_WORD_BITS-1];
              tx_word    <= {tx_word[`SDW_WORD_BITS-2:0], 1'b0};
            end else if (bits_left == `SDW_COUNT_RESET) begin
              tx_state  <= SDW_TX_GAP;
              gap_count <= 4'(GAP_CYC);
            end else begin
              bits_left <= bits_left - 5'h01;
            end
          end
        end
        SDW_TX_GAP: begin
          link.sync_n <= 1'b1;
          if (gap_count != 4'h0) begin
            gap_count <= gap_count - 4'h1;
          end else begin
            tx_state <= SDW_TX_IDLE;
          end
        end
        default: begin
          tx_state <= SDW_TX_IDLE;
        end
      endcase
    end
  end

  assign done_count_en = (tx_state == SDW_TX_SEND) && half_tick && link.sclk
                         && (bits_left == `SDW_COUNT_RESET) && !abort_req;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      frames_sent <= 16'h0000;
    end else if (done_count_en) begin
      frames_sent <= frames_sent + 16'h0001;
    end
  end
endmodule

// ### bench/sdw_link_checker.sv
// Concurrent checks on the write link and the converter end outputs
`timescale 1ns/1ps
module sdw_link_checker #(
  parameter int WAKE_NS   = 2500,
  parameter int CLOCK_MHZ = 25
) (
  input wire logic              clock,
  input wire logic              nrst,
  input wire logic              sync_n,
  input wire logic              sclk,
  input wire logic [15:0]       code,
  input sdw_pkg::sdw_mode_type  mode,
  input wire logic              amp_connected,
  input wire logic              term_1k,
  input wire logic              term_100k,
  input wire logic              output_valid,
  input wire logic              frame_applied,
  input wire logic              frame_aborted
);
  import sdw_pkg::*;
  // Slack of four cycles covers the sync and register stages
  localparam int WK_MAX = WAKE_NS * CLOCK_MHZ / 1000 + 4;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  //////////////////////////////////////////////////////////////
  // Applied pulse is registered beside code and mode, so both show on one edge
  AST_CODE_APPLY: assert property ($changed(code) |-> frame_applied)
    else $error("code changed with no frame applied");
  AST_MODE_APPLY: assert property ($changed(mode) |-> frame_applied)
    else $error("mode changed with no frame applied");
  AST_ABORT_KEEP: assert property (frame_aborted |-> $stable(code) && $stable(mode))
    else $error("aborted frame touched code or mode");
  AST_ONE_OUTCOME: assert property (frame_applied |-> !frame_aborted)
    else $error("frame both applied and aborted");
  AST_AMP_PATH: assert property (amp_connected == (mode == SDW_MODE_NORMAL))
    else $error("amplifier path does not follow mode");
  AST_TERM_SELECT: assert property (term_1k == (mode == SDW_MODE_PD_1K)
    && term_100k == (mode == SDW_MODE_PD_100K))
    else $error("termination does not follow mode");
  AST_PD_INVALID: assert property ((mode != SDW_MODE_NORMAL
    && $past(mode) != SDW_MODE_NORMAL) |-> !output_valid)
    else $error("output valid during power-down");
  AST_WAKE_HOLD: assert property ((mode == SDW_MODE_NORMAL
    && $past(mode) != SDW_MODE_NORMAL) |-> !output_valid [*4])
    else $error("output valid too early after wake");
  AST_WAKE_END: assert property ((mode == SDW_MODE_NORMAL
    && $past(mode) != SDW_MODE_NORMAL) |-> ##[1:WK_MAX] output_valid)
    else $error("output never valid after wake");
  AST_FRAME_START: assert property ($fell(sync_n) |-> !$past(sclk))
    else $error("frame started with shift clock not idle");
endmodule

// ### bench/test_serial_dac_write_and_power_modes.sv
// Self-checking bench: host and converter ends joined over the write link
`timescale 1ns/1ps
`include "sdw_regs.svh"
module test_serial_dac_write_and_power_modes;
  import sdw_pkg::*;
  logic         clock;
  logic         nrst;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [11:0]  paddr;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [15:0]  code;
  sdw_mode_type mode;
  logic         amp_connected;
  logic         term_1k;
  logic         term_100k;
  logic         output_valid;
  logic         frame_applied;
  logic         frame_aborted;
  logic         prev_sclk;
  logic         prev_sync;
  logic [23:0]  mon_word;
  int           mon_cnt;
  int           fail_count;
  int           checks_done;
  sdw_link_if sdw_link_if_i ();
  sdw_host sdw_host_i (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(sdw_link_if_i));
  sdw_device #(.WAKE_NS(200), .CLOCK_MHZ(25)) sdw_device_i (.clock(clock), .nrst(nrst),
    .link(sdw_link_if_i), .code(code), .mode(mode), .amp_connected(amp_connected),
    .term_1k(term_1k), .term_100k(term_100k), .output_valid(output_valid),
    .frame_applied(frame_applied), .frame_aborted(frame_aborted));
  sdw_link_checker #(.WAKE_NS(200), .CLOCK_MHZ(25)) sdw_link_checker_i (.clock(clock),
    .nrst(nrst), .sync_n(sdw_link_if_i.sync_n), .sclk(sdw_link_if_i.sclk), .code(code),
    .mode(mode), .amp_connected(amp_connected), .term_1k(term_1k), .term_100k(term_100k),
    .output_valid(output_valid), .frame_applied(frame_applied),
    .frame_aborted(frame_aborted));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  //////////////////////////////////////////////////////////////
  // Wire monitor on the falling clock so host updates have landed
  always @(negedge clock) begin
    prev_sclk <= sdw_link_if_i.sclk;
    prev_sync <= sdw_link_if_i.sync_n;
    if (!nrst || (prev_sync && !sdw_link_if_i.sync_n)) begin
      mon_cnt  <= 0;
      mon_word <= 24'h000000;
    end else if (!sdw_link_if_i.sync_n && prev_sclk && !sdw_link_if_i.sclk) begin
      mon_word <= {mon_word[22:0], sdw_link_if_i.sdata};
      mon_cnt  <= mon_cnt + 1;
    end
  end
  function automatic logic [31:0] exp_code(input logic [23:0] w);
    return {16'h0000, w[`SDW_CODE_MSB:`SDW_CODE_LSB]};
  endfunction
  function automatic logic [31:0] exp_mode(input logic [23:0] w);
    return {30'h0, w[`SDW_MODE_MSB:`SDW_MODE_LSB]};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("Checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle(output logic [31:0] q);
    logic e;
    int   n;
    n = 0;
    do begin
      apb(1'b0, `SDW_REG_STATUS, 32'h0, q, e);
      n++;
    end while (q[1] !== 1'b1 && n < 300);
    check("host idle", {31'h0, q[1]}, 32'h1);
  endtask
  task automatic send(input logic [23:0] w);
    logic [31:0] q;
    logic        e;
    int          n;
    apb(1'b1, `SDW_REG_DATA, {8'h00, w}, q, e);
    apb(1'b1, `SDW_REG_CTRL, 32'h00000001, q, e);
    n = 0;
    while (frame_applied !== 1'b1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    check("frame applied", {31'h0, frame_applied}, 32'h1);
    check("held code", {16'h0000, code}, exp_code(w));
    check("held mode", {30'h0, mode}, exp_mode(w));
    check("wire word", {8'h00, mon_word}, {8'h00, w});
    check("wire bit count", 32'(mon_cnt), 32'h18);
    wait_idle(q);
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q;
    logic        e;
    logic [23:0] w;
    logic [23:0] last;
    int          n;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fail_count = 0;
    checks_done = 0;
    void'($urandom(32'h8715));
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    @(negedge clock);
    check("reset code", {16'h0000, code}, 32'h0);
    check("reset mode", {30'h0, mode}, 32'h0);
    apb(1'b0, 12'h010, 32'h0, q, e);
    check("unmapped error", {31'h0, e}, 32'h1);
    check("unmapped data", q, 32'h0);
    apb(1'b1, `SDW_REG_DIV, 32'h0, q, e);
    apb(1'b0, `SDW_REG_DIV, 32'h0, q, e);
    check("divider", q, {24'h0, `SDW_DIV_RESET});
    // Reset divider is too fast for the device sampler
    apb(1'b1, `SDW_REG_DIV, 32'h3, q, e);
    $display("Test reset and registers done");
    for (int i = 0; i < 6; i++) begin
      w = 24'($urandom);
      w[17:16] = 2'(i % 4);
      if (i == 0) w[15:0] = 16'hFFFF;
      if (i == 1) w[15:0] = 16'h0000;
      send(w);
      last = w;
      n = 0;
      while (output_valid !== (w[17:16] == 2'h0) && n < 40) begin
        @(negedge clock);
        n++;
      end
      check("output valid", {31'h0, output_valid}, {31'h0, w[17:16] == 2'h0});
      check("amp path", {31'h0, amp_connected}, {31'h0, w[17:16] == 2'h0});
      check("term 1k", {31'h0, term_1k}, {31'h0, w[17:16] == 2'h1});
      check("term 100k", {31'h0, term_100k}, {31'h0, w[17:16] == 2'h2});
    end
    $display("Test modes and codes done");
    // Half period of 4 clocks gives the 320 ns link period
    apb(1'b1, `SDW_REG_DIV, 32'h4, q, e);
    w = 24'($urandom);
    send(w);
    last = w;
    $display("Test slow link done");
    apb(1'b1, `SDW_REG_DATA, {8'h00, ~last}, q, e);
    apb(1'b1, `SDW_REG_CTRL, 32'h00000001, q, e);
    repeat (40) @(posedge clock);
    apb(1'b1, `SDW_REG_CTRL, 32'h00000002, q, e);
    n = 0;
    while (frame_aborted !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    check("frame aborted", {31'h0, frame_aborted}, 32'h1);
    check("partial frame", {31'h0, mon_cnt < 24}, 32'h1);
    check("code kept", {16'h0000, code}, exp_code(last));
    check("mode kept", {30'h0, mode}, exp_mode(last));
    wait_idle(q);
    check("abort status", {31'h0, q[2]}, 32'h1);
    send(24'($urandom));
    // Eight complete frames sent; the cut one must not count
    apb(1'b0, `SDW_REG_STATUS, 32'h0, q, e);
    check("frames sent", {16'h0000, q[31:16]}, 32'h8);
    $display("Test abort done");
    results();
  end
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    $display("Error watchdog expired");
    results();
  end
endmodule
